//--- core/dvm_consts.vh
// Constants for the playback volume, mute and line-out control block
// Operation
// R1 - 8-bit volume code: 00H +6dB, 0.5dB steps to BFH, C0H mutes, reset 0CH
// R2 - One volume code sets left and right gain identically
// R3 - Applied gain ramps through intermediate codes on a volume change
// R4 - Full ramp takes 776/fs when select is 0 (reset), 194/fs when 1
// R5 - One code step per sample when fast, one per four samples when slow
// R6 - Soft mute set ramps output down to zero in the selected period
// R7 - Soft mute cleared ramps gain up from zero to the volume code
// R8 - Mute released mid-ramp returns gain to volume code in the same period
// R9 - Beep goes to speaker amp when speaker select and beep power are 1
// R10 - Beep goes to line amp whenever line select is 1
// R11 - Beep mode 0 internal (reset), 1 external; external ignores gain field
// R12 - Internal beep gain 0dB to -30dB in 6dB steps, then 3dB to -42dB
// R13 - Beep common level 1.15V when select 0 (reset), 1.65V when 1
// R14 - DAC-to-line 1 drives DAC onto line outputs, 0 holds common voltage (code drives them only in normal line mode, else zero)
// R15 - Line mode from power-save and power: down, normal, save fall or rise
// R16 - Line gain 00 0dB, 01 +2dB (reset), 10 +2dB, 11 +4dB, with common level
// R17 - Host powers up via power-save first, clears it after up to 300ms
// R18 - Host powers down via power-save first, clears it after up to 300ms
`ifndef DVM_CONSTS_VH
`define DVM_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define DVM_ADDR_VOL   8'h00
`define DVM_ADDR_CTRL  8'h04
`define DVM_ADDR_STAT  8'h08
`define DVM_VOL_RST    8'h0c
`define DVM_VOL_MUTE   8'hc0
`define DVM_CTRL_RST   16'h0400

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define DVM_C_TSEL   0
`define DVM_C_SOFT_MUTE_REQUEST  1
`define DVM_C_BSPK   2
`define DVM_C_BPWR   3
`define DVM_C_BLINE  4
`define DVM_C_BMODE  5
`define DVM_C_BVCM   6
`define DVM_C_DAC_TO_LINE_SELECT   7
`define DVM_C_LPWR   8
`define DVM_C_LPS    9
`define DVM_C_LG_HI  11
`define DVM_C_LG_LO  10
`define DVM_C_BG_HI  15
`define DVM_C_BG_LO  12

// ----------------------------------------
// Timing
// ----------------------------------------
`define DVM_CLK_HZ     20000000
`define DVM_FS_HZ      48000
`define DVM_FS_DIV     (`DVM_CLK_HZ / `DVM_FS_HZ)
`define DVM_RAMP_FAST  194
`define DVM_RAMP_SLOW  776
`define DVM_SLOW_DIV   (`DVM_RAMP_SLOW / `DVM_RAMP_FAST)
`define DVM_SLOW_LAST  2'd3
// Last count of the fs divider, clk/fs rounded down less one
`define DVM_FS_LAST    9'd415

// ----------------------------------------
// Gain arithmetic and line modes
// ----------------------------------------
`define DVM_GSTEP      8'd12
`define DVM_QBASE      6'd14
`define DVM_POS_MAX    24'h7fffff
`define DVM_NEG_MAX    24'h800000
`define DVM_LM_DOWN    2'd0
`define DVM_LM_NORM    2'd1
`define DVM_LM_FALL    2'd2
`define DVM_LM_RISE    2'd3
`define DVM_BG_BAD     6'h3f

`endif

//--- core/dvm_top.v
// Playback volume, soft mute, beep and line-out control with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "dvm_consts.vh"

module dvm_top (
	input  wire        clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg         hreadyout,
	output reg  [31:0] hrdata,
	output reg         hresp,
	input  wire [23:0] dacInLeft,
	input  wire [23:0] dacInRight,
	output reg  [23:0] leftLineOutput,
	output reg  [23:0] rightLineOutput,
	output reg         sampleTick,
	output reg         beepToSpeakerEn,
	output reg         beepToLineEn,
	output reg         beepExtMode,
	output reg  [5:0]  beepAttenDb,
	output reg         beepVcmHigh,
	output reg  [1:0]  lineOutMode,
	output reg  [2:0]  lineGainDb,
	output reg         lineVcmHigh
);

// ----------------------------------------
// Functions
// ----------------------------------------
// Mantissa of 10^(-k/40) in Q1.15
function [16:0] mant;
	input [3:0] k;
	begin
		case (k)
		4'd0:    mant = 17'd32768;
		4'd1:    mant = 17'd30935;
		4'd2:    mant = 17'd29205;
		4'd3:    mant = 17'd27571;
		4'd4:    mant = 17'd26029;
		4'd5:    mant = 17'd24573;
		4'd6:    mant = 17'd23198;
		4'd7:    mant = 17'd21900;
		4'd8:    mant = 17'd20675;
		4'd9:    mant = 17'd19519;
		4'd10:   mant = 17'd18427;
		4'd11:   mant = 17'd17396;
		default: mant = 17'd0;
		endcase
	end
endfunction

// Sample times gain of one code
function [23:0] scale;
	input [23:0] s;
	input [7:0]  code;
	reg   [7:0]         d;
	reg   [7:0]         r;
	reg   signed [41:0] p;
	begin
		d = code / `DVM_GSTEP;
		r = code - d * `DVM_GSTEP;
		p = $signed(s) * $signed({1'b0, mant(r[3:0])});
		p = p >>> (`DVM_QBASE + d[5:0]);
		if (code >= `DVM_VOL_MUTE) begin // [R1]
			scale = 24'h000000;
		end else if (!p[41] && (|p[41:23])) begin
			scale = `DVM_POS_MAX;
		end else if (p[41] && !(&p[41:23])) begin
			scale = `DVM_NEG_MAX;
		end else begin
			scale = p[23:0];
		end
	end
endfunction

// Internal beep gain code to attenuation in dB
function [5:0] beepDb;
	input [3:0] g;
	begin
		case (g)
		4'd0:    beepDb = 6'd0;
		4'd1:    beepDb = 6'd6;
		4'd2:    beepDb = 6'd12;
		4'd3:    beepDb = 6'd18;
		4'd4:    beepDb = 6'd24;
		4'd5:    beepDb = 6'd30;
		4'd6:    beepDb = 6'd33;
		4'd7:    beepDb = 6'd36;
		4'd8:    beepDb = 6'd39;
		4'd9:    beepDb = 6'd42;
		default: beepDb = `DVM_BG_BAD;
		endcase
	end
endfunction

// ----------------------------------------
// AHB-Lite slave
// ----------------------------------------
reg  [7:0]  volCode_ff;
reg  [15:0] ctrl_ff;
reg  [7:0]  appliedCode_ff;
reg         wrPend_ff;
reg  [7:0]  wrAddr_ff;
reg  [7:0]  nxt_volCode;
reg  [15:0] nxt_ctrl;
reg  [31:0] nxt_rdata;
wire        addrPhase;
wire        ramping;

assign addrPhase = hsel & hready & htrans[1];

always @* begin
	nxt_volCode = volCode_ff;
	nxt_ctrl = ctrl_ff;
	if (wrPend_ff && wrAddr_ff == `DVM_ADDR_VOL) begin
		nxt_volCode = hwdata[7:0];
	end
	if (wrPend_ff && wrAddr_ff == `DVM_ADDR_CTRL) begin
		nxt_ctrl = hwdata[15:0];
	end
end

// Read data forwarded from pending write
always @* begin
	case (haddr)
	`DVM_ADDR_VOL:  nxt_rdata = {24'h000000, nxt_volCode};
	`DVM_ADDR_CTRL: nxt_rdata = {16'h0000, nxt_ctrl};
	`DVM_ADDR_STAT: nxt_rdata = {21'h000000, lineOutMode,
		ramping, appliedCode_ff};
	default:        nxt_rdata = 32'h00000000;
	endcase
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		volCode_ff <= `DVM_VOL_RST; // [R1]
		ctrl_ff <= `DVM_CTRL_RST;
		wrPend_ff <= 1'b0;
		wrAddr_ff <= 8'h00;
		hrdata <= 32'h00000000;
		hreadyout <= 1'b0;
		hresp <= 1'b0;
	end else begin
		volCode_ff <= nxt_volCode;
		ctrl_ff <= nxt_ctrl;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wrPend_ff <= addrPhase & hwrite;
		if (addrPhase) begin
			wrAddr_ff <= haddr;
		end
		if (addrPhase && !hwrite) begin
			hrdata <= nxt_rdata;
		end
	end
end

// ----------------------------------------
// Sample rate divider
// ----------------------------------------
reg  [8:0] fsCnt_ff;
reg        fsTick_ff;
reg  [1:0] slowCnt_ff;
wire       stepTick;

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		fsCnt_ff <= 9'h000;
		fsTick_ff <= 1'b0;
	end else if (fsCnt_ff == `DVM_FS_LAST) begin
		fsCnt_ff <= 9'h000;
		fsTick_ff <= 1'b1;
	end else begin
		fsCnt_ff <= fsCnt_ff + 9'h001;
		fsTick_ff <= 1'b0;
	end
end

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		slowCnt_ff <= 2'd0;
	end else if (fsTick_ff) begin
		slowCnt_ff <= slowCnt_ff + 2'd1;
	end
end

// Fast: every sample; slow: every fourth
assign stepTick = fsTick_ff & (ctrl_ff[`DVM_C_TSEL] |
	(slowCnt_ff == `DVM_SLOW_LAST)); // [R4] [R5]

// ----------------------------------------
// Soft volume ramp
// ----------------------------------------
reg  [7:0] targetCode;
reg  [7:0] nxt_applied;

always @* begin
	if (ctrl_ff[`DVM_C_SOFT_MUTE_REQUEST]) begin
		targetCode = `DVM_VOL_MUTE; // [R6]
	end else if (volCode_ff > `DVM_VOL_MUTE) begin
		targetCode = `DVM_VOL_MUTE;
	end else begin
		targetCode = volCode_ff; // [R7] [R8]
	end
end

always @* begin
	nxt_applied = appliedCode_ff;
	if (stepTick && appliedCode_ff < targetCode) begin
		nxt_applied = appliedCode_ff + 8'h01; // [R3]
	end else if (stepTick && appliedCode_ff > targetCode) begin
		nxt_applied = appliedCode_ff - 8'h01; // [R3]
	end
end

assign ramping = (appliedCode_ff != targetCode);

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		appliedCode_ff <= `DVM_VOL_RST;
	end else begin
		appliedCode_ff <= nxt_applied;
	end
end

// ----------------------------------------
// Sample path to line outputs
// ----------------------------------------
reg  [1:0] nxt_lineMode;
wire       lineDrive;

always @* begin
	if (ctrl_ff[`DVM_C_LPS]) begin
		nxt_lineMode = ctrl_ff[`DVM_C_LPWR] ?
			`DVM_LM_RISE : `DVM_LM_FALL; // [R15]
	end else begin
		nxt_lineMode = ctrl_ff[`DVM_C_LPWR] ?
			`DVM_LM_NORM : `DVM_LM_DOWN; // [R15]
	end
end

assign lineDrive = ctrl_ff[`DVM_C_DAC_TO_LINE_SELECT] &
	(lineOutMode == `DVM_LM_NORM); // [R14]

always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		leftLineOutput <= 24'h000000;
		rightLineOutput <= 24'h000000;
		sampleTick <= 1'b0;
	end else begin
		sampleTick <= fsTick_ff;
		if (fsTick_ff && lineDrive) begin
			// Both channels share the applied code
			leftLineOutput <= scale(dacInLeft, appliedCode_ff); // [R2]
			rightLineOutput <= scale(dacInRight, appliedCode_ff); // [R2]
		end else if (fsTick_ff) begin
			leftLineOutput <= 24'h000000; // [R14]
			rightLineOutput <= 24'h000000; // [R14]
		end
	end
end

// ----------------------------------------
// Beep and line analog control
// ----------------------------------------
always @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		beepToSpeakerEn <= 1'b0;
		beepToLineEn <= 1'b0;
		beepExtMode <= 1'b0;
		beepAttenDb <= 6'd0;
		beepVcmHigh <= 1'b0;
		lineOutMode <= `DVM_LM_DOWN;
		lineGainDb <= 3'd2;
		lineVcmHigh <= 1'b1;
	end else begin
		beepToSpeakerEn <= ctrl_ff[`DVM_C_BSPK] &
			ctrl_ff[`DVM_C_BPWR]; // [R9]
		beepToLineEn <= ctrl_ff[`DVM_C_BLINE]; // [R10]
		beepExtMode <= ctrl_ff[`DVM_C_BMODE]; // [R11]
		if (ctrl_ff[`DVM_C_BMODE]) begin
			beepAttenDb <= 6'd0; // [R11]
		end else begin
			beepAttenDb <= beepDb(
				ctrl_ff[`DVM_C_BG_HI:`DVM_C_BG_LO]); // [R12]
		end
		beepVcmHigh <= ctrl_ff[`DVM_C_BVCM]; // [R13]
		lineOutMode <= nxt_lineMode; // [R15]
		case (ctrl_ff[`DVM_C_LG_HI:`DVM_C_LG_LO])
		2'd0:    lineGainDb <= 3'd0; // [R16]
		2'd1:    lineGainDb <= 3'd2; // [R16]
		2'd2:    lineGainDb <= 3'd2; // [R16]
		default: lineGainDb <= 3'd4; // [R16]
		endcase
		lineVcmHigh <= ctrl_ff[`DVM_C_LG_LO]; // [R16]
	end
end

endmodule // dvm_top
`default_nettype wire

//--- test/dvm_top_chk.sv
// Port checker for the volume, mute and line-out block
`timescale 1ns/1ps
`default_nettype none
module dvm_top_chk (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hresp,
	input wire logic [23:0] dacInLeft,
	input wire logic [23:0] dacInRight,
	input wire logic [23:0] leftLineOutput,
	input wire logic [23:0] rightLineOutput,
	input wire logic        sampleTick,
	input wire logic        beepExtMode,
	input wire logic [5:0]  beepAttenDb,
	input wire logic [1:0]  lineOutMode,
	input wire logic [2:0]  lineGainDb,
	input wire logic        lineVcmHigh
);
	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_quiet; !sampleTick [*8]; endsequence
	sequence s_zero; leftLineOutput == 24'h0 && rightLineOutput == 24'h0; endsequence
	property p_tick; sampleTick |=> s_quiet; endproperty
	property p_quiet; sampleTick && $past(lineOutMode) != 2'h1 |-> s_zero; endproperty
	property p_pair;
		sampleTick && $stable(dacInLeft) && dacInLeft == dacInRight
			|-> leftLineOutput == rightLineOutput;
	endproperty
	property p_ext; beepExtMode |-> beepAttenDb == 6'h0; endproperty
	property p_att; beepAttenDb inside {0, 6, 12, 18, 24, 30, 33, 36, 39, 42, 63}; endproperty
	property p_gain; lineGainDb inside {0, 2, 4}; endproperty
	property p_vcm; lineGainDb != 3'h2 |-> lineVcmHigh == lineGainDb[2]; endproperty
	property p_okay; hresp == 1'b0; endproperty
	a_tick: assert property (p_tick) else $error("sample tick too close");
	a_quiet: assert property (p_quiet) else $error("line out not silent");
	a_pair: assert property (p_pair) else $error("channels differ");
	a_ext: assert property (p_ext) else $error("external mode attenuates");
	a_att: assert property (p_att) else $error("beep attenuation off table");
	a_gain: assert property (p_gain) else $error("line gain off table");
	a_vcm: assert property (p_vcm) else $error("line common level wrong");
	a_okay: assert property (p_okay) else $error("response not okay");
endmodule // dvm_top_chk
bind dvm_top dvm_top_chk u_chk (.clk, .rst_n, .hresp, .dacInLeft, .dacInRight,
	.leftLineOutput, .rightLineOutput, .sampleTick, .beepExtMode, .beepAttenDb,
	.lineOutMode, .lineGainDb, .lineVcmHigh);
`default_nettype wire

//--- test/tb_dvm_top.sv
// Self-checking bench for the volume, mute and line-out block
`timescale 1ns/1ps
`default_nettype none
module tb_dvm_top;
	logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
	logic [7:0]  haddr = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 0, rd, st = 4;
	logic [23:0] dac = 0;
	logic [15:0] c;
	logic [5:0]  ba;
	wire         hrdy, hresp, tick, bSpk, bLine, bExt, bVcm, lVcm;
	wire  [31:0] hrdata;
	wire  [23:0] outL, outR;
	wire  [5:0]  bAtt;
	wire  [1:0]  lMode;
	wire  [2:0]  lGain;
	logic [31:0] q[$], sq[$];
	int          errors = 0, num_checks = 0, n;
	event        obs;
	dvm_top uut (.clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hrdy), .hreadyout(hrdy), .hrdata, .hresp, .dacInLeft(dac),
		.dacInRight(dac), .leftLineOutput(outL), .rightLineOutput(outR),
		.sampleTick(tick), .beepToSpeakerEn(bSpk), .beepToLineEn(bLine),
		.beepExtMode(bExt), .beepAttenDb(bAtt), .beepVcmHigh(bVcm),
		.lineOutMode(lMode), .lineGainDb(lGain), .lineVcmHigh(lVcm));
	always #25 clk = ~clk;
	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] rnd();
		st = st ^ (st << 13);
		st = st ^ (st >> 17);
		st = st ^ (st << 5);
		return st;
	endfunction
	task automatic check(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic close_out();
		while (q.size() > 0) check(sq.pop_front(), q.pop_front());
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic note(input logic [31:0] s, e);
		sq.push_back(s);
		q.push_back(e);
		->obs;
	endtask
	always @(obs) while (q.size() > 0) check(sq.pop_front(), q.pop_front());
	task automatic waitFor(input logic t);
		for (n = 0; n < 1000; n++) begin
			@(posedge clk);
			if ((t ? tick : hrdy) === 1'b1) return;
		end
		errors++;
		close_out();
	endtask
	task automatic ticks(input int k);
		repeat (k) begin
			waitFor(1);
			dac <= 24'(rnd());
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		waitFor(0);
		htrans <= 2'h0;
		hsel <= 0;
		hwdata <= d;
		waitFor(0);
		rd = hrdata;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 0);
		note(rd, e);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		rdChk(8'h00, 32'h0c);
		rdChk(8'h04, 32'h0400);
		rdChk(8'h08, 32'h0c);
		bus(1, 8'h0c, 32'hffffffff);
		rdChk(8'h0c, 0);
		for (int i = 0; i < 16; i++) begin
			c = {i[3:0], i[3:0], 8'(rnd()) & 8'hfd};
			bus(1, 8'h04, {16'h0, c});
			repeat (2) @(posedge clk);
			ba = c[15:12] < 6 ? c[15:12] * 6 : c[15:12] < 10 ? 15 + c[15:12] * 3 : 63;
			note(bSpk, c[2] & c[3]);
			note(bLine, c[4]);
			note(bAtt, c[5] ? 6'h0 : ba);
			note(bVcm, c[6]);
			note(bExt, c[5]);
			note(lMode, c[9:8]);
			note(lGain, c[11:10] == 0 ? 0 : c[11:10] == 3 ? 4 : 2);
			note(lVcm, c[10]);
			rdChk(8'h04, c);
		end
		bus(1, 8'h04, 32'h0680);
		ticks(2);
		bus(0, 8'h08, 0);
		note(rd[10:9], 2'h2);
		bus(1, 8'h04, 32'h0480);
		bus(1, 8'h04, 32'h0680);
		bus(1, 8'h04, 32'h0781);
		ticks(2);
		note(outL, 0);
		bus(0, 8'h08, 0);
		note(rd[10:9], 2'h3);
		bus(1, 8'h04, 32'h0581);
		ticks(3);
		note(outL != 0 && outL === outR, 1);
		bus(1, 8'h04, 32'h0501);
		ticks(3);
		note(outL, 0);
		bus(1, 8'h04, 32'h0581);
		bus(1, 8'h00, 32'h14);
		ticks(4);
		bus(0, 8'h08, 0);
		note(rd[8] && rd[7:0] > 8'h0e && rd[7:0] < 8'h12, 1);
		ticks(8);
		rdChk(8'h08, 32'h214);
		bus(1, 8'h04, 32'h0580);
		bus(1, 8'h00, 32'h10);
		ticks(8);
		bus(0, 8'h08, 0);
		note(rd[8] && rd[7:0] > 8'h10 && rd[7:0] < 8'h14, 1);
		ticks(16);
		rdChk(8'h08, 32'h210);
		bus(1, 8'h04, 32'h0583);
		ticks(6);
		bus(0, 8'h08, 0);
		note(rd[8] && rd[7:0] > 8'h14 && rd[7:0] < 8'h18, 1);
		bus(1, 8'h04, 32'h0581);
		ticks(10);
		rdChk(8'h08, 32'h210);
		close_out();
	end
endmodule // tb_dvm_top
`default_nettype wire
